// file: pkg/otpcs_map.svh
// register offsets, field positions and burn pulse length of the otp configuration store
`ifndef OTPCS_MAP_SVH
`define OTPCS_MAP_SVH
`define OTPCS_ADDR_W 8
`define OTPCS_OFS_THR0 8'h0F
`define OTPCS_OFS_THR1 8'h10
`define OTPCS_OFS_THR2 8'h11
`define OTPCS_OFS_MAKER_LO 8'h12
`define OTPCS_OFS_MAKER_HI 8'h13
`define OTPCS_OFS_PART_LO 8'h14
`define OTPCS_OFS_PART_HI 8'h15
`define OTPCS_OFS_POWER 8'h16
`define OTPCS_OFS_ATTR 8'h17
`define OTPCS_OFS_REL_MAJ 8'h18
`define OTPCS_OFS_REL_MIN 8'h19
`define OTPCS_OFS_FLUSH 8'h1A
`define OTPCS_OFS_FLAGS_A 8'h1D
`define OTPCS_OFS_FLAGS_B 8'h1E
`define OTPCS_FIRST_OFS 8'h0F
`define OTPCS_NUM_LOC 16
// attribute field positions
`define OTPCS_ATTR_WAKE_EN 3
`define OTPCS_ATTR_WAKE_VALID 2
`define OTPCS_ATTR_PMODE_HI 1
`define OTPCS_ATTR_PMODE_LO 0
`define OTPCS_ATTR_USED 8'h0F
`define OTPCS_BMATTR_BASE 8'h80
`define OTPCS_BMATTR_SELF 6
`define OTPCS_BMATTR_WAKE 5
// flush option bits
`define OTPCS_FL_RX_CLOSE 4
`define OTPCS_FL_RX_OPEN 3
`define OTPCS_FL_TX_CLOSE 2
`define OTPCS_FL_TX_OPEN 1
`define OTPCS_FL_USED 8'h1E
// flag byte b bit positions
`define OTPCS_FB_MAKER_TEXT_B 7
`define OTPCS_FB_MAKER_TEXT_A 6
`define OTPCS_FB_FLUSH 5
`define OTPCS_FB_RELEASE 4
`define OTPCS_FB_ATTR 3
`define OTPCS_FB_POWER 2
`define OTPCS_FB_PART 1
`define OTPCS_FB_MAKER 0
// burn pulse length
`define OTPCS_BURN_NS 1000
`define OTPCS_CLK_NS 20
`define OTPCS_BURN_CYC ((`OTPCS_BURN_NS + `OTPCS_CLK_NS - 1) / `OTPCS_CLK_NS)
`endif

// file: pkg/otpcs_pkg.sv
// types of the otp configuration store
package otpcs_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } otpcs_req_t;
    typedef struct packed {
        logic rvalid;
        logic [7:0] rdata;
        logic refused;
    } otpcs_rsp_t;
    typedef struct packed {
        logic [23:0] rate_threshold;
        logic [15:0] maker_code;
        logic [15:0] part_code;
        logic [7:0] max_power;
        logic [7:0] bm_attributes;
        logic [7:0] release_major;
        logic [7:0] release_minor;
    } otpcs_cfg_t;
    typedef struct packed {
        logic rx_on_close;
        logic rx_on_open;
        logic tx_on_close;
        logic tx_on_open;
    } otpcs_flush_t;
    typedef enum logic [1:0] {
        OTPCS_IDLE = 2'b10,
        OTPCS_READ = 2'b01,
        OTPCS_BURN = 2'b00,
        OTPCS_LOAD = 2'b11
    } otpcs_state_t;
endpackage

// file: verilog/otpcs_array.sv
// small otp array model: one byte per location, registered read, burns only set bits
`timescale 1ns/100ps
module otpcs_array #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock
    input wire logic ref_clk,
    // port
    input wire logic burn,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] cells [DEPTH] = '{default: 8'h00}; // blank fuses read as zero

    // fuses only ever go from 0 to 1, so a burn ors into the cell
    always_ff @(posedge ref_clk) begin
        if (burn) begin
            cells[addr] <= cells[addr] | wdata;
        end
        rdata <= cells[addr];
    end
endmodule

// file: verilog/otpcs_store.sv
// otp configuration store: staging registers, burn sequencer, descriptor outputs
//
// Function
// - the 24-bit rate threshold is bytes 0x0F (7:0), 0x10 (15:8) and 0x11 (23:16).
// - the maker code is byte 0x12 as low byte and 0x13 as high byte.
// - the part code is byte 0x14 as low byte and 0x15 as high byte.
// - the power byte is reported as bMaxPower; the host keeps it within 0x01 to 0xFA.
// - remote wake enable goes into bmAttributes D5 only while the wake-valid bit is set.
// - power mode 00 reports bus powered, 01 and 10 self powered; the host never writes 11.
// - rx fifo flush on close when flush bit 4 is set, on open when bit 3 is set.
// - tx fifo flush on close when flush bit 2 is set, on open when bit 1 is set.
// - a field other than the rate threshold is loaded from otp only when its burned flag is 1; the threshold is always read.
// - flag byte a holds language, channel 3..0 pins, serial text, product text b and a in bits 7..0.
// - flag byte b holds maker text b, maker text a, flush, release, attributes, power, part, maker in 7..0.
// - a field whose flag is burned refuses every further programming.
// - setting a flag burns the field as staged, zeros wherever it was never written.
`timescale 1ns/100ps
`include "otpcs_map.svh"
module otpcs_store #(
    parameter logic [23:0] DEF_THRESHOLD = 24'h000000,
    parameter logic [15:0] DEF_MAKER = 16'h1234, // arbitrary value
    parameter logic [15:0] DEF_PART = 16'h5678, // arbitrary value
    parameter logic [7:0] DEF_POWER = 8'h32,
    parameter logic [7:0] DEF_ATTR = 8'h00,
    parameter logic [7:0] DEF_REL_MAJ = 8'h01,
    parameter logic [7:0] DEF_REL_MIN = 8'h00,
    parameter logic [7:0] DEF_FLUSH = 8'h00
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register port from the usb side
    input wire otpcs_pkg::otpcs_req_t req,
    output otpcs_pkg::otpcs_rsp_t rsp,
    output logic busy,
    // serial port events
    input wire logic port_open,
    input wire logic port_close,
    // results
    output otpcs_pkg::otpcs_cfg_t cfg,
    output logic [7:0] field_burned_flags_a,
    output logic [7:0] field_burned_flags_b,
    output logic flush_rx,
    output logic flush_tx,
    output logic load_done
);
    import otpcs_pkg::*;

    localparam int AW = 4;
    localparam int NLOC = `OTPCS_NUM_LOC;
    localparam int BURN_CYC = `OTPCS_BURN_CYC;
    localparam logic [7:0] FIRST = `OTPCS_FIRST_OFS;

    otpcs_state_t state;
    logic [7:0] stage [NLOC];
    logic [AW-1:0] idx;
    logic [AW-1:0] burn_end;
    logic [AW-1:0] arr_addr;
    logic [7:0] arr_rdata;
    logic [7:0] cnt;
    logic [7:0] burned_a;
    logic [7:0] burned_b;
    logic [7:0] live [NLOC];
    logic arr_burn;
    logic refused_q;
    logic rvalid_q;
    logic [7:0] rdata_q;
    logic flag_wr;
    logic flag_new;

    // location index of an offset, and whether the offset is mapped
    function automatic logic [AW-1:0] loc_of(input logic [7:0] a);
        logic [7:0] d;
        d = a - FIRST;
        return d[AW-1:0];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a >= FIRST) && (a <= `OTPCS_OFS_FLAGS_B) && (a != 8'h1B) && (a != 8'h1C);
    endfunction

    // flag bit that guards an offset; flags guard themselves per bit, handled apart
    function automatic logic field_done(input logic [7:0] a, input logic [7:0] fb);
        logic r;
        r = 1'b0;
        unique case (a)
            `OTPCS_OFS_MAKER_LO, `OTPCS_OFS_MAKER_HI: r = fb[`OTPCS_FB_MAKER];
            `OTPCS_OFS_PART_LO, `OTPCS_OFS_PART_HI: r = fb[`OTPCS_FB_PART];
            `OTPCS_OFS_POWER: r = fb[`OTPCS_FB_POWER];
            `OTPCS_OFS_ATTR: r = fb[`OTPCS_FB_ATTR];
            `OTPCS_OFS_REL_MAJ, `OTPCS_OFS_REL_MIN: r = fb[`OTPCS_FB_RELEASE];
            `OTPCS_OFS_FLUSH: r = fb[`OTPCS_FB_FLUSH];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // value of a location as the device uses it: otp if burned, default otherwise
    function automatic logic [7:0] pick(input logic done, input logic [7:0] otp, input logic [7:0] def);
        return done ? otp : def;
    endfunction

    // same choice for the two-byte codes; the byte-wide one would drop the high byte
    function automatic logic [15:0] pick16(input logic done, input logic [15:0] otp, input logic [15:0] def);
        return done ? otp : def;
    endfunction

    // flag bits of a flag write that are not burned yet; anything else in it is refused
    function automatic logic [7:0] fresh_bits(input logic [7:0] a, input logic [7:0] d, input logic [7:0] fa,
        input logic [7:0] fb);
        logic [7:0] r;
        r = 8'h00;
        if (a == `OTPCS_OFS_FLAGS_A) begin
            r = d & ~fa;
        end else if (a == `OTPCS_OFS_FLAGS_B) begin
            r = d & ~fb;
        end
        return r;
    endfunction

    otpcs_array #(
        .DEPTH(NLOC),
        .AW(AW)
    ) u_array (
        .ref_clk(ref_clk),
        .burn(arr_burn),
        .addr(arr_addr),
        .wdata(stage[idx]),
        .rdata(arr_rdata)
    );

    // one burn strobe at the end of each pulse span, so every cell gets the full burn time
    assign arr_burn = (state == OTPCS_BURN) && (cnt == 8'h00);
    assign arr_addr = (state == OTPCS_IDLE) ? loc_of(req.addr) : idx;

    // a flag write that adds no bit burns nothing; a repeat of burned bits is only refused
    assign flag_wr = req.wr && (req.addr == `OTPCS_OFS_FLAGS_A || req.addr == `OTPCS_OFS_FLAGS_B);
    assign flag_new = |fresh_bits(req.addr, req.wdata, burned_a, burned_b);

    // sequencer: load all locations after reset, then burn on a flag write
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= OTPCS_READ;
            idx <= '0;
            cnt <= 8'h00;
            burn_end <= '0;
        end else begin
            unique case (state)
                OTPCS_READ: begin
                    state <= OTPCS_LOAD; // array read takes one cycle
                end
                OTPCS_LOAD: begin
                    if (idx == AW'(NLOC - 1)) begin
                        state <= OTPCS_IDLE;
                        idx <= '0;
                    end else begin
                        idx <= idx + 1'b1;
                        state <= OTPCS_READ;
                    end
                end
                OTPCS_IDLE: begin
                    if (flag_wr && flag_new) begin
                        // burning the whole staged map; or-burn keeps old fuses intact
                        state <= OTPCS_BURN;
                        idx <= '0;
                        burn_end <= AW'(NLOC - 1);
                        cnt <= 8'(BURN_CYC);
                    end
                end
                OTPCS_BURN: begin
                    if (cnt != 8'h00) begin
                        cnt <= cnt - 8'h01;
                    end else if (idx == burn_end) begin
                        idx <= '0;
                        state <= OTPCS_READ; // reload so outputs follow the new fuses
                    end else begin
                        idx <= idx + 1'b1;
                        cnt <= 8'(BURN_CYC);
                    end
                end
            endcase
        end
    end

    // loaded copy of the array
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NLOC; i++) begin
                live[i] <= 8'h00;
            end
        end else if (state == OTPCS_LOAD) begin
            live[idx] <= arr_rdata;
        end
    end

    assign burned_a = live[loc_of(`OTPCS_OFS_FLAGS_A)];
    assign burned_b = live[loc_of(`OTPCS_OFS_FLAGS_B)];

    // staging writes; burned fields and burned flag bits are refused
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NLOC; i++) begin
                stage[i] <= 8'h00; // unwritten portions burn as zero
            end
            refused_q <= 1'b0;
        end else begin
            refused_q <= 1'b0;
            if (req.wr && state == OTPCS_IDLE && mapped(req.addr)) begin
                if (req.addr == `OTPCS_OFS_FLAGS_A) begin
                    stage[loc_of(req.addr)] <= fresh_bits(req.addr, req.wdata, burned_a, burned_b);
                    refused_q <= |(req.wdata & burned_a);
                end else if (req.addr == `OTPCS_OFS_FLAGS_B) begin
                    stage[loc_of(req.addr)] <= fresh_bits(req.addr, req.wdata, burned_a, burned_b);
                    refused_q <= |(req.wdata & burned_b);
                end else if (field_done(req.addr, burned_b)) begin
                    refused_q <= 1'b1;
                end else if (req.addr == `OTPCS_OFS_ATTR) begin
                    stage[loc_of(req.addr)] <= req.wdata & `OTPCS_ATTR_USED; // reserved kept zero
                end else if (req.addr == `OTPCS_OFS_FLUSH) begin
                    stage[loc_of(req.addr)] <= req.wdata & `OTPCS_FL_USED;
                end else begin
                    stage[loc_of(req.addr)] <= req.wdata;
                end
            end else if (req.wr) begin
                refused_q <= 1'b1; // busy or unmapped
            end
        end
    end

    // reads answer one cycle later with the loaded otp byte, not the default
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            rvalid_q <= req.rd;
            if (req.rd && mapped(req.addr)) begin
                rdata_q <= live[loc_of(req.addr)];
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // answer fields come from flops of two processes, so they are gathered here
    assign rsp = '{rvalid: rvalid_q, rdata: rdata_q, refused: refused_q};

    // descriptor values, default where the field is not burned
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg <= '0;
            field_burned_flags_a <= 8'h00;
            field_burned_flags_b <= 8'h00;
            busy <= 1'b1;
            load_done <= 1'b0;
        end else begin
            cfg.rate_threshold <= {live[loc_of(`OTPCS_OFS_THR2)], live[loc_of(`OTPCS_OFS_THR1)],
                live[loc_of(`OTPCS_OFS_THR0)]}; // always read, no flag covers it
            cfg.maker_code <= pick16(burned_b[`OTPCS_FB_MAKER], {live[loc_of(`OTPCS_OFS_MAKER_HI)],
                live[loc_of(`OTPCS_OFS_MAKER_LO)]}, DEF_MAKER);
            cfg.part_code <= pick16(burned_b[`OTPCS_FB_PART], {live[loc_of(`OTPCS_OFS_PART_HI)],
                live[loc_of(`OTPCS_OFS_PART_LO)]}, DEF_PART);
            cfg.max_power <= pick(burned_b[`OTPCS_FB_POWER], live[loc_of(`OTPCS_OFS_POWER)],
                DEF_POWER);
            cfg.bm_attributes <= bm_attr(pick(burned_b[`OTPCS_FB_ATTR], live[loc_of(`OTPCS_OFS_ATTR)],
                DEF_ATTR));
            cfg.release_major <= pick(burned_b[`OTPCS_FB_RELEASE], live[loc_of(`OTPCS_OFS_REL_MAJ)],
                DEF_REL_MAJ);
            cfg.release_minor <= pick(burned_b[`OTPCS_FB_RELEASE], live[loc_of(`OTPCS_OFS_REL_MIN)],
                DEF_REL_MIN);
            field_burned_flags_a <= burned_a;
            field_burned_flags_b <= burned_b;
            busy <= (state != OTPCS_IDLE);
            load_done <= (state == OTPCS_IDLE);
        end
    end

    // bmAttributes from the stored attribute byte
    function automatic logic [7:0] bm_attr(input logic [7:0] a);
        logic [7:0] b;
        b = `OTPCS_BMATTR_BASE;
        b[`OTPCS_BMATTR_SELF] = a[`OTPCS_ATTR_PMODE_HI] | a[`OTPCS_ATTR_PMODE_LO]; // 00 bus, 01/10 self
        b[`OTPCS_BMATTR_WAKE] = a[`OTPCS_ATTR_WAKE_VALID] & a[`OTPCS_ATTR_WAKE_EN];
        return b;
    endfunction

    logic [7:0] flush_opt;
    assign flush_opt = pick(burned_b[`OTPCS_FB_FLUSH], live[loc_of(`OTPCS_OFS_FLUSH)], DEF_FLUSH);

    // flush pulses one cycle after the port event
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flush_rx <= 1'b0;
            flush_tx <= 1'b0;
        end else begin
            flush_rx <= (port_close & flush_opt[`OTPCS_FL_RX_CLOSE]) |
                (port_open & flush_opt[`OTPCS_FL_RX_OPEN]);
            flush_tx <= (port_close & flush_opt[`OTPCS_FL_TX_CLOSE]) |
                (port_open & flush_opt[`OTPCS_FL_TX_OPEN]);
        end
    end
endmodule

// file: tb/otpcs_host.sv
// host-side programming model driving the store's register port
`timescale 1ns/100ps
module otpcs_host (
    // clock
    input wire logic ref_clk,
    // register port
    input wire otpcs_pkg::otpcs_rsp_t rsp,
    output otpcs_pkg::otpcs_req_t req
);
    import otpcs_pkg::*;
    // idle port from time zero
    initial req = '0;
    // an idle edge first so back-to-back calls never drive req twice in one step
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, output otpcs_rsp_t r);
        @(posedge ref_clk);
        #1;
        req = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge ref_clk);
        #1;
        // released lines show the inverse so stale values never pass
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        r = rsp;
    endtask
    // software write with the host's own obligations applied
    task automatic write(input logic [7:0] a, input logic [7:0] d, output logic refused);
        otpcs_rsp_t r;
        logic [7:0] m;
        m = (a == 8'h17) ? 8'h0F : ((a == 8'h1A) ? 8'h1E : 8'hFF); // reserved bits written zero
        if (a == 8'h16 && (d < 8'h01 || d > 8'hFA)) d = 8'h01; // power byte kept in range
        if (a == 8'h17 && d[1:0] == 2'b11) d[1:0] = 2'b01; // invalid power mode never sent
        access(1'b1, a, d & m, r);
        refused = r.refused;
    endtask
    // software read, unknown when no answer came
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        otpcs_rsp_t r;
        access(1'b0, a, 8'h00, r);
        d = (r.rvalid === 1'b1) ? r.rdata : 8'hXX;
    endtask
endmodule

// file: tb/otpcs_store_properties.sv
// concurrent checks on the ports of the otp configuration store
`timescale 1ns/100ps
module otpcs_store_properties (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register port
    input wire otpcs_pkg::otpcs_req_t req,
    input wire otpcs_pkg::otpcs_rsp_t rsp,
    input wire logic busy,
    // port events
    input wire logic port_open,
    input wire logic port_close,
    // results
    input wire otpcs_pkg::otpcs_cfg_t cfg,
    input wire logic [7:0] field_burned_flags_a,
    input wire logic [7:0] field_burned_flags_b,
    input wire logic flush_rx,
    input wire logic flush_tx,
    input wire logic load_done
);
    import otpcs_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_read_answer;
        !busy && req.rd |=> rsp.rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_burned_refused;
        !busy && req.wr && field_burned_flags_b[0] && req.addr inside {8'h12, 8'h13} |=> rsp.refused;
    endproperty
    a_burned_refused: assert property (p_burned_refused) else $error("burned field accepted");
    property p_flag_reburn;
        !busy && req.wr && req.addr == 8'h1E && |(req.wdata & field_burned_flags_b) |=> rsp.refused;
    endproperty
    a_flag_reburn: assert property (p_flag_reburn) else $error("burned flag accepted again");
    property p_burn_start;
        !busy && req.wr && req.addr == 8'h1D && req.wdata != 8'h00 && !(|(req.wdata & field_burned_flags_a))
            |-> ##2 busy [*8];
    endproperty
    a_burn_start: assert property (p_burn_start) else $error("flag write did not burn");
    property p_rx_cause;
        flush_rx |-> $past(port_open || port_close);
    endproperty
    a_rx_cause: assert property (p_rx_cause) else $error("rx flush without event");
    property p_tx_cause;
        flush_tx |-> $past(port_open || port_close);
    endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("tx flush without event");
    property p_no_flush_default;
        (port_open || port_close) && load_done && !field_burned_flags_b[5] |=> !flush_rx && !flush_tx;
    endproperty
    a_no_flush_default: assert property (p_no_flush_default) else $error("flush while unburned");
    property p_attr_default;
        load_done && !field_burned_flags_b[3] |-> cfg.bm_attributes == 8'h80;
    endproperty
    a_attr_default: assert property (p_attr_default) else $error("attributes not default");
    property p_maker_default;
        load_done && !field_burned_flags_b[0] |-> cfg.maker_code == 16'h1234;
    endproperty
    a_maker_default: assert property (p_maker_default) else $error("maker code not default");
endmodule
bind otpcs_store otpcs_store_properties i_otpcs_store_properties (.ref_clk(ref_clk), .reset_n(reset_n),
    .req(req), .rsp(rsp), .busy(busy), .port_open(port_open), .port_close(port_close), .cfg(cfg),
    .field_burned_flags_a(field_burned_flags_a), .field_burned_flags_b(field_burned_flags_b),
    .flush_rx(flush_rx), .flush_tx(flush_tx), .load_done(load_done));

// file: tb/testbench.sv
// self-checking bench of the otp configuration store
`timescale 1ns/100ps
module testbench;
    import otpcs_pkg::*;
    logic ref_clk;
    logic reset_n;
    logic port_open;
    logic port_close;
    logic busy;
    logic load_done;
    logic flush_rx;
    logic flush_tx;
    logic [7:0] flags_a;
    logic [7:0] flags_b;
    logic r;
    logic [7:0] d;
    otpcs_req_t req;
    otpcs_rsp_t rsp;
    otpcs_cfg_t cfg;
    int fails;
    int num_checks;
    // staged bytes: part high byte left out, release staged but never flagged
    localparam logic [15:0] STG [10] = '{16'h0FA1, 16'h10B2, 16'h11C3, 16'h12CD, 16'h13AB,
        16'h1401, 16'h16FA, 16'h170D, 16'h1807, 16'h1A12};
    localparam logic [7:0] AGAIN [9] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h1A, 8'h1E, 8'h18};
    otpcs_store i_otpcs_store (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .rsp(rsp), .busy(busy),
        .port_open(port_open), .port_close(port_close), .cfg(cfg), .field_burned_flags_a(flags_a),
        .field_burned_flags_b(flags_b), .flush_rx(flush_rx), .flush_tx(flush_tx), .load_done(load_done));
    otpcs_host i_otpcs_host (.ref_clk(ref_clk), .rsp(rsp), .req(req));
    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // bounded wait for the sequencer, long enough for a full burn and reload
    task automatic wait_idle;
        int n;
        n = 0;
        // busy is registered behind the sequencer, so let one edge pass first
        @(posedge ref_clk);
        #1;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(96'(busy), 96'h0);
        check(96'(load_done), 96'h1);
    endtask
    // one port event, flush pulses looked at in the following cycle
    task automatic event_pulse(input logic open, input logic [1:0] exp);
        @(posedge ref_clk);
        #1;
        port_open = open;
        port_close = !open;
        @(posedge ref_clk);
        #1;
        port_open = 1'b0;
        port_close = 1'b0;
        check(96'({flush_rx, flush_tx}), 96'(exp));
    endtask
    task automatic complete_run;
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog, about ten times the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        complete_run();
    end
    initial begin
        reset_n = 1'b0;
        port_open = 1'b0;
        port_close = 1'b0;
        fails = 0;
        num_checks = 0;
        repeat (10) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        wait_idle();
        check(96'(cfg), 96'({24'h0, 16'h1234, 16'h5678, 8'h32, 8'h80, 8'h01, 8'h00}));
        check(96'({flags_a, flags_b}), 96'h0);
        event_pulse(1'b0, 2'b00);
        event_pulse(1'b1, 2'b00);
        // fields staged before any flag is set, part high byte left out
        foreach (STG[i]) begin
            i_otpcs_host.write(STG[i][15:8], STG[i][7:0], r);
            check(96'(r), 96'h0);
        end
        i_otpcs_host.write(8'h1E, 8'h2F, r);
        check(96'(r), 96'h0);
        wait_idle();
        check(96'(cfg), 96'({24'hC3B2A1, 16'hABCD, 16'h0001, 8'hFA, 8'hE0, 8'h01, 8'h00}));
        check(96'(flags_b), 96'h2F);
        i_otpcs_host.read(8'h12, d);
        check(96'(d), 96'hCD);
        i_otpcs_host.read(8'h15, d);
        check(96'(d), 96'h00);
        // burned fields and flags refuse, the unflagged release byte does not
        foreach (AGAIN[i]) begin
            i_otpcs_host.write(AGAIN[i], 8'h01, r);
            check(96'(r), 96'(AGAIN[i] != 8'h18));
        end
        event_pulse(1'b0, 2'b10);
        event_pulse(1'b1, 2'b01);
        i_otpcs_host.write(8'h1D, 8'h81, r);
        check(96'(r), 96'h0);
        wait_idle();
        check(96'({flags_a, flags_b}), 96'h812F);
        check(96'(cfg.maker_code), 96'hABCD);
        complete_run();
    end
endmodule
